/* File: src/oswc_consts.svh */
// Purpose: Constants of the oscillator settle-wait and bus-wait block.
// Assumes: Included by its bare name from every file that needs it.
// Notes:   Exponents are counts of crystal periods as powers of two.
`ifndef OSWC_CONSTS_SVH
`define OSWC_CONSTS_SVH

`define OSWC_ADDR_STATUS   16'hffa3
`define OSWC_ADDR_SELECT   16'hffa4
`define OSWC_ADDR_WAITCTL  16'hfffd

`define OSWC_RST_STATUS    8'h00
`define OSWC_RST_SELECT    8'h05
`define OSWC_RST_WAITCTL   8'h00

`define OSWC_SEL_LSB       0
`define OSWC_SEL_W         3
`define OSWC_STAT_LSB      0
`define OSWC_STAT_W        5
`define OSWC_TWOWAIT_BIT   1

`define OSWC_SEL_2E11      3'h1
`define OSWC_SEL_2E13      3'h2
`define OSWC_SEL_2E14      3'h3
`define OSWC_SEL_2E15      3'h4
`define OSWC_SEL_2E16      3'h5

`define OSWC_EXP_2E11      11
`define OSWC_EXP_2E13      13
`define OSWC_EXP_2E14      14
`define OSWC_EXP_2E15      15
`define OSWC_EXP_2E16      16

`define OSWC_CNT_W         17
`define OSWC_WAIT_STATES   2'h2

`endif

/* File: src/oswc_pkg.sv */
// Purpose: Types shared by the settle-wait block and its counter.
// Assumes: Constants come from oswc_consts.svh.
// Notes:   Status bit i maps to a fixed exponent through stat_exp.
`include "oswc_consts.svh"

package oswc_pkg;

	typedef enum logic [1:0] {
		OSWC_ST_RUN  = 2'b00,
		OSWC_ST_STOP = 2'b01,
		OSWC_ST_WAIT = 2'b10
	} oswc_state_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic        rd;
		logic        bitOp;
		logic [2:0]  bitSel;
		logic [7:0]  wdata;
	} oswc_cpu_req_t;

	typedef struct packed {
		logic ext;
		logic power_on_clear_reset;
		logic low_voltage_reset;
		logic wdt;
	} oswc_rst_src_t;

	// Status bit 4 is the shortest wait, bit 0 the longest.
	function automatic int stat_exp(input int idx);
		case (idx)
			4: stat_exp = `OSWC_EXP_2E11;
			3: stat_exp = `OSWC_EXP_2E13;
			2: stat_exp = `OSWC_EXP_2E14;
			1: stat_exp = `OSWC_EXP_2E15;
			default: stat_exp = `OSWC_EXP_2E16;
		endcase
	endfunction : stat_exp

endpackage : oswc_pkg

/* File: src/oswc_settle_counter.sv */
// Purpose: Crystal-period counter with thermometer status and a stop point.
// Assumes: tick is a one-cycle enable per crystal period, synchronous to mclk.
// Notes:   The count saturates at the selected threshold, so status is sticky.
`timescale 1ns/1ps
`include "oswc_consts.svh"

module oswc_settle_counter #(
	parameter int CNT_W     = `OSWC_CNT_W,
	parameter int EXP_SHIFT = 0
) (
	// Clock and reset
	input  wire logic                    mclk,
	input  wire logic                    rst,
	// Control
	input  wire logic                    clear,
	input  wire logic                    tick,
	input  wire logic                    running,
	input  wire logic [2:0]              stopIdx,
	// State
	output logic      [CNT_W-1:0]        count_r,
	output logic      [`OSWC_STAT_W-1:0] statusBits,
	output logic                         reached
);
	import oswc_pkg::*;

	generate
		if (CNT_W < `OSWC_CNT_W || EXP_SHIFT < 0 || EXP_SHIFT > 10) begin : g_bad
			$error("oswc_settle_counter: unsupported CNT_W or EXP_SHIFT");
		end
	endgenerate

	genvar i;
	generate
		for (i = 0; i < `OSWC_STAT_W; i++) begin : g_thr
			localparam logic [CNT_W-1:0] THR =
				{{(CNT_W-1){1'b0}}, 1'b1} << (stat_exp(i) - EXP_SHIFT);
			assign statusBits[i] = (count_r >= THR);
		end
	endgenerate

	assign reached = statusBits[stopIdx];

	// Counting waits for oscillation and freezes at the selected wait.
	always_ff @(posedge mclk) begin
		if (rst || clear) begin
			count_r <= '0;
		end else if (tick && running && !reached) begin
			count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

endmodule : oswc_settle_counter

/* File: src/oswc_top.sv */
// Purpose: Crystal settle-wait timing, settle select and data-access wait control.
// Assumes: All inputs synchronous to mclk; xtalTick pulses once per crystal period.
// Notes:   The oscillator halt bit itself lives outside; this block obeys it.
//
// Overview of operation
// - Status clears on reset, STOP, oscillator halt.
// - Status bits set in order, stay set.
// - Status read-only, bit or byte reads.
// - Counter freezes at the selected wait.
// - Counting begins only after oscillation starts.
// - Select codes one to five pick waits.
// - Crystal CPU clock held until wait ends.
// - Select resets to five, byte writes only.
// - Wait bit adds two data wait states.
// - Wait control clears on external reset.
// - Halt bit starts and stops crystal.
// - Halt low runs, halt high stops.
`timescale 1ns/1ps
`include "oswc_consts.svh"

module oswc_top #(
	parameter int CNT_W     = `OSWC_CNT_W,
	parameter int EXP_SHIFT = 0
) (
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   rst,
	// Reset sources, high while active
	input  wire oswc_pkg::oswc_rst_src_t rstSrc,
	// CPU memory access
	input  wire oswc_pkg::oswc_cpu_req_t cpuReq,
	output logic      [7:0]             rdData_r,
	output logic                        rdBit_r,
	output logic                        rdValid_r,
	// Standby and clock status
	input  wire logic                   stopExec,
	input  wire logic                   stopRelease,
	input  wire logic                   hsOscHalt,
	input  wire logic                   cpuOnCrystal,
	// Crystal oscillator
	input  wire logic                   xtalRunning,
	input  wire logic                   xtalTick,
	output logic                        xtalOscEnable,
	// CPU hold and data wait
	output logic                        cpuHold,
	input  wire logic                   dataAccess,
	output logic                        dataWait,
	output logic                        twoWaitEnable
);
	import oswc_pkg::*;

	generate
		if (CNT_W < `OSWC_CNT_W) begin : g_bad
			$error("oswc_top: CNT_W too small for the longest wait");
		end
	endgenerate

	// Maps a select code to the status bit that ends its wait.
	// Prohibited codes fall back to the longest wait, which is the safe side.
	function automatic logic [2:0] sel_to_idx(input logic [2:0] sel);
		case (sel)
			`OSWC_SEL_2E11: sel_to_idx = 3'h4;
			`OSWC_SEL_2E13: sel_to_idx = 3'h3;
			`OSWC_SEL_2E14: sel_to_idx = 3'h2;
			`OSWC_SEL_2E15: sel_to_idx = 3'h1;
			`OSWC_SEL_2E16: sel_to_idx = 3'h0;
			default:        sel_to_idx = 3'h0;
		endcase
	endfunction : sel_to_idx

	// Applies a single-bit write to a byte.
	function automatic logic [7:0] bit_merge(input logic [7:0] old,
		input logic [2:0] pos, input logic val);
		logic [7:0] tmp;
		tmp = old;
		tmp[pos] = val;
		bit_merge = tmp;
	endfunction : bit_merge

	logic                    anyReset;
	logic                    settleClear;
	logic                    wrSelect;
	logic                    wrWaitCtl;
	logic                    rdHit;
	logic [7:0]              statusByte;
	logic [7:0]              selectByte;
	logic [7:0]              waitCtlByte;
	logic [7:0]              waitCtlWr;
	logic [7:0]              rdByte;
	logic [2:0]              settleSel_r;
	logic                    twoWait_r;
	logic [1:0]              waitCnt_r;
	logic                    holdOnXtal_r;
	oswc_state_t             state_r;
	oswc_state_t             state_nxt;
	logic [CNT_W-1:0]        settleCount;
	logic [`OSWC_STAT_W-1:0] settleStatus;
	logic                    settleReached;

	// Full reset bytes, so that each stored field is cut from them on purpose.
	localparam logic [7:0] SEL_RST_BYTE  = `OSWC_RST_SELECT;
	localparam logic [7:0] WAIT_RST_BYTE = `OSWC_RST_WAITCTL;

	assign anyReset = rstSrc.ext | rstSrc.power_on_clear_reset | rstSrc.low_voltage_reset | rstSrc.wdt;

	// Held clear for the whole reset so the count starts fresh at release.
	assign settleClear = anyReset | stopExec | hsOscHalt;

	oswc_settle_counter #(
		.CNT_W     (CNT_W),
		.EXP_SHIFT (EXP_SHIFT)
	) u_counter (
		.mclk       (mclk),
		.rst        (rst),
		.clear      (settleClear),
		.tick       (xtalTick),
		.running    (xtalRunning),
		.stopIdx    (sel_to_idx(settleSel_r)),
		.count_r    (settleCount),
		.statusBits (settleStatus),
		.reached    (settleReached)
	);

	// Register decode.
	assign wrSelect  = cpuReq.wr && !cpuReq.bitOp &&
		(cpuReq.addr == `OSWC_ADDR_SELECT);
	assign wrWaitCtl = cpuReq.wr && (cpuReq.addr == `OSWC_ADDR_WAITCTL);
	assign rdHit     = (cpuReq.addr == `OSWC_ADDR_STATUS) ||
		(cpuReq.addr == `OSWC_ADDR_SELECT) ||
		(cpuReq.addr == `OSWC_ADDR_WAITCTL);

	assign statusByte  = {{(8-`OSWC_STAT_W){1'b0}}, settleStatus};
	assign selectByte  = {{(8-`OSWC_SEL_W){1'b0}}, settleSel_r};
	assign waitCtlByte = {6'h00, twoWait_r, 1'b0};

	// Only the wait bit is stored; the others must be written as zero anyway.
	assign waitCtlWr = cpuReq.bitOp ?
		bit_merge(waitCtlByte, cpuReq.bitSel, cpuReq.wdata[0]) : cpuReq.wdata;

	always_comb begin
		rdByte = 8'h00;
		if (cpuReq.addr == `OSWC_ADDR_STATUS) begin
			rdByte = statusByte;
		end else if (cpuReq.addr == `OSWC_ADDR_SELECT) begin
			rdByte = selectByte;
		end else if (cpuReq.addr == `OSWC_ADDR_WAITCTL) begin
			rdByte = waitCtlByte;
		end
	end

	// Settle select; any reset source restores the longest wait.
	always_ff @(posedge mclk) begin
		if (rst || anyReset) begin
			settleSel_r <= SEL_RST_BYTE[`OSWC_SEL_LSB +: `OSWC_SEL_W];
		end else if (wrSelect) begin
			settleSel_r <= cpuReq.wdata[`OSWC_SEL_LSB +: `OSWC_SEL_W];
		end
	end

	// Wait control is cleared only by rst and the external reset source.
	always_ff @(posedge mclk) begin
		if (rst || rstSrc.ext) begin
			twoWait_r <= WAIT_RST_BYTE[`OSWC_TWOWAIT_BIT];
		end else if (wrWaitCtl) begin
			twoWait_r <= waitCtlWr[`OSWC_TWOWAIT_BIT];
		end
	end

	// Read port; writes to the status address have no effect.
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdData_r  <= 8'h00;
			rdBit_r   <= 1'b0;
			rdValid_r <= 1'b0;
		end else begin
			rdValid_r <= cpuReq.rd;
			if (cpuReq.rd) begin
				rdData_r <= rdHit ? rdByte : 8'h00;
				rdBit_r  <= rdByte[cpuReq.bitSel];
			end
		end
	end

	// STOP sequencing.
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			OSWC_ST_RUN: begin
				if (stopExec) begin
					state_nxt = OSWC_ST_STOP;
				end
			end
			OSWC_ST_STOP: begin
				if (stopRelease) begin
					state_nxt = OSWC_ST_WAIT;
				end
			end
			OSWC_ST_WAIT: begin
				if (!holdOnXtal_r || settleReached) begin
					state_nxt = OSWC_ST_RUN;
				end
			end
			default: begin
				state_nxt = OSWC_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst || anyReset) begin
			state_r <= OSWC_ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// The clock source is caught at STOP entry, when it is known to be stable.
	always_ff @(posedge mclk) begin
		if (rst || anyReset) begin
			holdOnXtal_r <= 1'b0;
		end else if (state_r == OSWC_ST_RUN && stopExec) begin
			holdOnXtal_r <= cpuOnCrystal;
		end
	end

	assign cpuHold = (state_r == OSWC_ST_STOP) ||
		(state_r == OSWC_ST_WAIT && holdOnXtal_r);

	// The crystal stays off during STOP and whenever the halt bit is set.
	assign xtalOscEnable = !hsOscHalt && (state_r != OSWC_ST_STOP);

	// Data-access wait states.
	always_ff @(posedge mclk) begin
		if (rst) begin
			waitCnt_r <= 2'h0;
		end else if (waitCnt_r != 2'h0) begin
			waitCnt_r <= waitCnt_r - 2'h1;
		end else if (dataAccess && twoWait_r) begin
			waitCnt_r <= `OSWC_WAIT_STATES;
		end
	end

	assign dataWait      = (waitCnt_r != 2'h0);
	assign twoWaitEnable = twoWait_r;

endmodule : oswc_top

/* File: sim/oswc_top_monitor.sv */
// Purpose: Port checker for the settle-wait block.
// Assumes: One clock, sync active-high reset.
// Notes:   Bound to the top module below.
`timescale 1ns/1ps

module oswc_top_monitor (
	// Clock and reset
	input wire logic                    mclk,
	input wire logic                    rst,
	// Observed ports
	input wire oswc_pkg::oswc_cpu_req_t cpuReq,
	input wire logic [7:0]              rdData_r,
	input wire logic                    rdValid_r,
	input wire logic                    hsOscHalt,
	input wire logic                    xtalOscEnable,
	input wire logic                    cpuHold,
	input wire logic                    dataAccess,
	input wire logic                    dataWait,
	input wire logic                    twoWaitEnable
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_wait_start;
		dataAccess && twoWaitEnable && !dataWait;
	endsequence

	a_rd_answer: assert property (cpuReq.rd |=> rdValid_r)
		else $error("read not answered");
	a_no_stray_valid: assert property (!cpuReq.rd |=> !rdValid_r)
		else $error("stray read valid");
	a_status_high_zero: assert property (rdValid_r && $past(cpuReq.addr) == 16'hffa3
		|-> rdData_r[7:5] == 3'h0) else $error("status upper bits set");
	a_select_high_zero: assert property (rdValid_r && $past(cpuReq.addr) == 16'hffa4
		|-> rdData_r[7:3] == 5'h00) else $error("select upper bits set");
	a_halt_stops_osc: assert property (hsOscHalt |-> !xtalOscEnable)
		else $error("oscillator runs while halted");
	a_osc_runs_free: assert property (!hsOscHalt && !cpuHold |-> xtalOscEnable)
		else $error("oscillator stopped while released");
	a_two_wait_states: assert property (s_wait_start |=> dataWait [*2] ##1 !dataWait)
		else $error("data wait not two cycles");
	a_no_wait_off: assert property (!twoWaitEnable && !dataWait |=> !dataWait)
		else $error("data wait while disabled");
endmodule : oswc_top_monitor

bind oswc_top oswc_top_monitor u_mon (.mclk, .rst, .cpuReq, .rdData_r, .rdValid_r,
	.hsOscHalt, .xtalOscEnable, .cpuHold, .dataAccess, .dataWait, .twoWaitEnable);

/* File: sim/oswc_top_tb_top.sv */
// Purpose: Self-checking bench for the settle-wait block.
// Assumes: EXP_SHIFT of 10 gives thresholds 2, 8, 16, 32, 64.
// Notes:   Status model saturates the tick count at the selected wait.
`timescale 1ns/1ps

module oswc_top_tb_top;
	import oswc_pkg::*;
	logic          mclk, rst, stopExec, stopRelease, hsOscHalt, cpuOnCrystal;
	logic          xtalRunning, xtalTick, dataAccess, rdBit_r, rdValid_r;
	logic          xtalOscEnable, cpuHold, dataWait, twoWaitEnable;
	logic [7:0]    rdData_r;
	oswc_rst_src_t rstSrc;
	oswc_cpu_req_t cpuReq;
	int            failures = 0, checkCount = 0, cycles = 0, nTicks;
	logic [31:0]   seed = 32'h00211e03;
	int            thr[5] = '{2, 8, 16, 32, 64};

	oswc_top #(.EXP_SHIFT(10)) u_oswc_top (.mclk, .rst, .rstSrc, .cpuReq, .rdData_r,
		.rdBit_r, .rdValid_r, .stopExec, .stopRelease, .hsOscHalt, .cpuOnCrystal,
		.xtalRunning, .xtalTick, .xtalOscEnable, .cpuHold, .dataAccess, .dataWait,
		.twoWaitEnable);

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// A hang in a bounded wait would otherwise run forever.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			end_of_test();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [7:0] expStat(int c, int n);
		logic [7:0] s = 8'h00;
		int         cnt = (n < thr[c-1]) ? n : thr[c-1];
		for (int i = 0; i < 5; i++) begin
			if (cnt >= thr[i]) s[4-i] = 1'b1;
		end
		return s;
	endfunction : expStat

	task automatic chk(logic [7:0] got, logic [7:0] exp);
		checkCount++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chk1(logic g, logic e);
		chk({7'h0, g}, {7'h0, e});
	endtask : chk1

	task automatic pulse(ref logic s);
		@(posedge mclk) #1;
		s = 1'b1;
		@(posedge mclk) #1;
		s = 1'b0;
	endtask : pulse

	task automatic ticks(int n);
		repeat (n) pulse(xtalTick);
	endtask : ticks

	task automatic wr(logic [15:0] a, logic [7:0] d, logic b);
		@(posedge mclk) #1;
		cpuReq = '{a, 1'b1, 1'b0, b, 3'h1, d};
		@(posedge mclk) #1;
		cpuReq.wr = 1'b0;
	endtask : wr

	task automatic rd(logic [15:0] a, logic [7:0] e);
		@(posedge mclk) #1;
		cpuReq = '{a, 1'b0, 1'b1, 1'b0, 3'h4, 8'h00};
		@(posedge mclk) #1;
		cpuReq.rd = 1'b0;
		chk1(rdValid_r, 1'b1);
		chk(rdData_r, e);
		chk1(rdBit_r, e[4]);
	endtask : rd

	task automatic end_of_test();
		$display("checks=%0d failures=%0d", checkCount, failures);
		if (failures == 0 && checkCount > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	initial begin
		rst = 1'b1;
		rstSrc = '0;
		cpuReq = '0;
		{stopExec, stopRelease, hsOscHalt, cpuOnCrystal, xtalTick, dataAccess} = '0;
		// The crystal is the high-speed source, so the fixed software wait never applies.
		xtalRunning = 1'b1;
		repeat (2) @(posedge mclk);
		#1 rst = 1'b0;
		rd(16'hffa3, 8'h00);
		rd(16'hffa4, 8'h05);
		rd(16'hfffd, 8'h00);
		rd(16'h1234, 8'h00);
		$display("reset test done");
		for (int c = 1; c <= 5; c++) begin
			nTicks = int'(rnd() % 32'd80);
			wr(16'hffa4, 8'hf8 | c[7:0], 1'b0);
			wr(16'hffa4, 8'h01, 1'b1);
			rd(16'hffa4, c[7:0]);
			pulse(hsOscHalt);
			xtalRunning = 1'b0;
			ticks(3);
			xtalRunning = 1'b1;
			ticks(nTicks);
			wr(16'hffa3, 8'hff, 1'b0);
			rd(16'hffa3, expStat(c, nTicks));
		end
		$display("select test done");
		wr(16'hffa4, 8'h01, 1'b0);
		cpuOnCrystal = 1'b1;
		pulse(hsOscHalt);
		ticks(2);
		rd(16'hffa3, 8'h10);
		pulse(stopExec);
		chk1(cpuHold, 1'b1);
		rd(16'hffa3, 8'h00);
		pulse(stopRelease);
		ticks(1);
		chk1(cpuHold, 1'b1);
		ticks(1);
		@(posedge mclk) #1;
		chk1(cpuHold, 1'b0);
		rd(16'hffa3, 8'h10);
		$display("stop test done");
		wr(16'hfffd, 8'h01, 1'b1);
		rd(16'hfffd, 8'h02);
		pulse(dataAccess);
		chk1(dataWait, 1'b1);
		@(posedge mclk) #1;
		chk1(dataWait, 1'b1);
		@(posedge mclk) #1;
		chk1(dataWait, 1'b0);
		rstSrc = 4'b0100;
		@(posedge mclk) #1;
		rstSrc = '0;
		rd(16'hfffd, 8'h02);
		rd(16'hffa4, 8'h05);
		rstSrc = 4'b1000;
		@(posedge mclk) #1;
		rstSrc = '0;
		rd(16'hfffd, 8'h00);
		pulse(dataAccess);
		chk1(dataWait, 1'b0);
		$display("wait test done");
		end_of_test();
	end
endmodule : oswc_top_tb_top
